// file: src/plb_block.sv
`timescale 1ns/1ns
`default_nettype none

module plb_block (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [plb_pkg::GBUFS-1:0] global_buffer,
  input  wire logic                  rt_clk,
  input  wire logic                  rt_ce,
  input  wire logic                  rt_sr,
  input  wire logic [31:0]           cell_in,
  input  wire logic                  fast_carry_in,
  output logic [plb_pkg::CELLS-1:0]  cell_out,
  output logic                       fast_carry_out
);

  plb_pkg::plb_ctrl_s ctrl_ff;
  logic [7:0]         outsel_ff;
  logic [7:0]         srval_ff;
  logic [15:0]        lut_init_ff [plb_pkg::CELLS];
  logic [7:0]         ff_q_ff;
  logic [7:0]         cell_out_ff;
  logic               carry_out_ff;
  logic [31:0]        prdata_ff;
  logic               pready_ff;
  logic               pslverr_ff;

  // global buffer synchronisers
  logic [7:0]         gb_s1_ff;
  logic [7:0]         gb_s2_ff;
  logic [7:0]         gb_s3_ff;
  logic [7:0]         gb_lvl_ff;
  logic               clk_prev_ff;
  wire                clk_src = ctrl_ff.clk_rt ? rt_clk : gb_lvl_ff[ctrl_ff.clk_idx];

  // ---------------- apb slave ----------------
  wire                hit_ctrl   = paddr == plb_pkg::OFF_CTRL;
  wire                hit_outsel = paddr == plb_pkg::OFF_OUTSEL;
  wire                hit_srval  = paddr == plb_pkg::OFF_SRVAL;
  wire                hit_status = paddr == plb_pkg::OFF_STATUS;
  wire                hit_lut    = ((paddr & plb_pkg::LUT_MASK) == plb_pkg::OFF_LUT) && (paddr[1:0] == 2'h0);
  wire [2:0]          lut_idx    = paddr[4:2];
  wire                hit_any    = hit_ctrl | hit_outsel | hit_srval | hit_status | hit_lut;
  wire                access     = psel & penable & ~pready_ff;
  wire                wr_done    = psel & penable & pready_ff & pwrite & hit_any;

  plb_pkg::plb_status_s status;
  assign status.rsvd      = '0;
  assign status.cfg_hold  = ctrl_ff.cfg_hold;
  assign status.carry_out = carry_out_ff;
  assign status.cell_out  = cell_out_ff;
  assign status.ff_q      = ff_q_ff;

  wire [31:0] rd_val = hit_ctrl   ? {16'h0000, ctrl_ff} :
                       hit_outsel ? {24'h000000, outsel_ff} :
                       hit_srval  ? {24'h000000, srval_ff} :
                       hit_status ? status :
                       hit_lut    ? {16'h0000, lut_init_ff[lut_idx]} : 32'h00000000;

  // one wait state; write lands on the edge that sees pready
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= access;
      pslverr_ff <= access & ~hit_any;
      prdata_ff  <= (access & ~pwrite) ? rd_val : 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_ff   <= plb_pkg::RST_CTRL;
      outsel_ff <= plb_pkg::RST_OUTSEL;
      srval_ff  <= plb_pkg::RST_SRVAL;
      for (int i = 0; i < plb_pkg::CELLS; i++) begin
        lut_init_ff[i] <= plb_pkg::RST_LUT;
      end
    end else if (wr_done) begin
      if (hit_ctrl) begin
        ctrl_ff <= plb_pkg::plb_ctrl_s'(pwdata[15:0]);
      end
      if (hit_outsel) begin
        outsel_ff <= pwdata[7:0];
      end
      if (hit_srval) begin
        srval_ff <= pwdata[7:0];
      end
      if (hit_lut) begin
        lut_init_ff[lut_idx] <= pwdata[15:0];
      end
    end
  end

  // ---------------- control distribution ----------------
  // a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      gb_s1_ff    <= 8'h00;
      gb_s2_ff    <= 8'h00;
      gb_s3_ff    <= 8'h00;
      gb_lvl_ff   <= 8'h00;
      clk_prev_ff <= 1'b0;
    end else begin
      gb_s1_ff    <= global_buffer;
      gb_s2_ff    <= gb_s1_ff;
      gb_s3_ff    <= gb_s2_ff;
      gb_lvl_ff   <= (gb_s2_ff & gb_s3_ff) | (gb_lvl_ff & (gb_s2_ff | gb_s3_ff));
      clk_prev_ff <= clk_src;
    end
  end

  // block clock becomes a one-cycle tick on the rising edge of the source
  wire       tick    = clk_src & ~clk_prev_ff;
  wire [2:0] sr_sel  = {ctrl_ff.sr_idx, 1'b0};
  wire [2:0] ce_sel  = {ctrl_ff.ce_idx, 1'b1};
  wire       sr_lvl  = ctrl_ff.sr_rt ? rt_sr : gb_lvl_ff[sr_sel];
  wire       ce_lvl  = ctrl_ff.ce_rt ? rt_ce : gb_lvl_ff[ce_sel];
  wire       ce_eff  = ~ctrl_ff.ce_used | ce_lvl;
  wire       capture = tick & ce_eff;
  // async acts every cycle; sync waits for an enabled block clock edge
  wire       sr_act  = ctrl_ff.sr_used & sr_lvl & (~ctrl_ff.sr_sync | capture);
  wire       gsr     = ctrl_ff.cfg_hold;

  // ---------------- logic cells ----------------
  logic [plb_pkg::CELLS-1:0] lut_out;
  logic [plb_pkg::CELLS:0]   carry;
  logic [plb_pkg::CELLS-1:0] nxt_ff_q;
  logic [plb_pkg::CELLS-1:0] nxt_cell_out;

  assign carry[0] = fast_carry_in;

  for (genvar g = 0; g < plb_pkg::CELLS; g++) begin : g_cell
    wire [3:0] addr = cell_in[g*plb_pkg::LUT_IN +: plb_pkg::LUT_IN];
    // any four-input function: the init word is the truth table
    assign lut_out[g] = lut_init_ff[g][addr];
    // carry from inputs one and two, propagating or generating
    assign carry[g+1] = (addr[1] & addr[2]) | (carry[g] & (addr[1] ^ addr[2]));
    assign nxt_ff_q[g] = gsr    ? plb_pkg::WAKE_STATE[g] :
                         sr_act ? srval_ff[g] :
                         capture ? lut_out[g] : ff_q_ff[g];
    assign nxt_cell_out[g] = outsel_ff[g] ? nxt_ff_q[g] : lut_out[g];
  end

  // outputs are flopped, so the lookup path costs one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      ff_q_ff      <= plb_pkg::WAKE_STATE;
      cell_out_ff  <= 8'h00;
      carry_out_ff <= 1'b0;
    end else begin
      ff_q_ff      <= nxt_ff_q;
      cell_out_ff  <= nxt_cell_out;
      carry_out_ff <= carry[plb_pkg::CELLS];
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign cell_out       = cell_out_ff;
  assign fast_carry_out = carry_out_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_gsr_wake_state:
    assert property (gsr |=> ff_q_ff == plb_pkg::WAKE_STATE)
    else $error("global reset did not force wake-up state");

  a_srst_clears_ff:
    assert property ($fell(srst) |-> $past(ff_q_ff) == plb_pkg::WAKE_STATE)
    else $error("flip-flops not cleared by reset");

  a_lut_rom_read:
    assert property (!outsel_ff[0] |=> cell_out_ff[0] == $past(lut_init_ff[0][cell_in[3:0]]))
    else $error("cell output is not the addressed lookup bit");

  a_reg_out_sel:
    assert property (outsel_ff[3] && !gsr ##1 outsel_ff[3] |-> cell_out_ff[3] == ff_q_ff[3])
    else $error("registered output does not follow flip-flop");

  a_ff_hold_quiet:
    assert property (!tick && !(ctrl_ff.sr_used && sr_lvl) && !gsr |=> ff_q_ff == $past(ff_q_ff))
    else $error("flip-flop changed with no clock, set/reset or global reset");

  a_ce_gates_all:
    assert property (ctrl_ff.ce_used && !ce_lvl && !gsr && !(ctrl_ff.sr_used && sr_lvl && !ctrl_ff.sr_sync)
                     |=> $stable(ff_q_ff))
    else $error("clock enable low but flip-flops changed");

  a_async_sr_now:
    assert property (ctrl_ff.sr_used && !ctrl_ff.sr_sync && sr_lvl && !gsr |=> ff_q_ff == $past(srval_ff))
    else $error("asynchronous set/reset did not act at once");

  a_sync_sr_waits:
    assert property (ctrl_ff.sr_used && ctrl_ff.sr_sync && sr_lvl && !tick && !gsr |=> $stable(ff_q_ff))
    else $error("synchronous set/reset acted without a clock edge");

  a_sr_even_buf:
    assert property (!ctrl_ff.sr_rt && !gb_lvl_ff[{ctrl_ff.sr_idx, 1'b0}] |-> !sr_lvl)
    else $error("set/reset taken from an odd buffer");

  a_rt_clock_tick:
    assert property (ctrl_ff.clk_rt ##1 (ctrl_ff.clk_rt && $rose(rt_clk)) |-> tick)
    else $error("routing clock edge gave no tick");

  a_carry_chain:
    assert property ((cell_in == 32'h22222222) |=> fast_carry_out == $past(fast_carry_in))
    else $error("carry did not ripple through all cells");

  a_apb_one_wait:
    assert property (psel && penable && !pready_ff |=> pready_ff)
    else $error("apb answer not after one wait state");

  a_ready_one_pulse:
    assert property (pready_ff |=> !pready_ff)
    else $error("apb ready stood longer than one cycle");

  a_err_unmapped:
    assert property (access && !hit_any |=> pslverr_ff)
    else $error("unmapped address gave no error");

  a_no_err_mapped:
    assert property (access && hit_any |=> !pslverr_ff)
    else $error("mapped address gave an error");

  a_err_with_ready:
    assert property (pslverr_ff |-> pready_ff)
    else $error("error flagged without ready");

  // read data must be zero outside the answer so stale words never leak
  a_rdata_idle_zero:
    assert property (!pready_ff |-> prdata_ff == 32'h00000000)
    else $error("read data not zero while idle");

  a_rdata_latched:
    assert property (access && !pwrite |=> prdata_ff == $past(rd_val))
    else $error("read data not taken at the access edge");

  a_ctrl_write_lands:
    assert property (wr_done && hit_ctrl |=> ctrl_ff == $past(pwdata[15:0]))
    else $error("control write did not land");

  a_outsel_write_lands:
    assert property (wr_done && hit_outsel |=> outsel_ff == $past(pwdata[7:0]))
    else $error("output select write did not land");

  a_srval_write_lands:
    assert property (wr_done && hit_srval |=> srval_ff == $past(pwdata[7:0]))
    else $error("set/reset value write did not land");

  a_lut_write_lands:
    assert property (wr_done && hit_lut |=> lut_init_ff[$past(lut_idx)] == $past(pwdata[15:0]))
    else $error("lookup contents write did not land");

  a_bad_write_ignored:
    assert property (psel && penable && pready_ff && pwrite && !hit_any
                     |=> $stable(ctrl_ff) && $stable(outsel_ff) && $stable(srval_ff))
    else $error("unmapped write changed a register");

  a_status_read_only:
    assert property (wr_done && hit_status |=> $stable(ctrl_ff) && $stable(outsel_ff) && $stable(srval_ff))
    else $error("status write changed a register");

  a_capture_loads_lut:
    assert property (capture && !gsr && !sr_act |=> ff_q_ff == $past(lut_out))
    else $error("enabled clock edge did not load the lookup result");

  a_ce_unused_free:
    assert property (!ctrl_ff.ce_used && tick && !gsr && !sr_act |=> ff_q_ff == $past(lut_out))
    else $error("unused enable blocked a capture");

  a_sr_unused_quiet:
    assert property (!ctrl_ff.sr_used && !capture && !gsr |=> $stable(ff_q_ff))
    else $error("flip-flops forced with set/reset unused");

  a_sync_sr_on_tick:
    assert property (ctrl_ff.sr_used && ctrl_ff.sr_sync && sr_lvl && capture && !gsr
                     |=> ff_q_ff == $past(srval_ff))
    else $error("synchronous set/reset missed its clock edge");

  a_lut_last_cell:
    assert property (!outsel_ff[7] |=> cell_out_ff[7] == $past(lut_init_ff[7][cell_in[31:28]]))
    else $error("last cell output is not its lookup bit");

  a_carry_kill:
    assert property (cell_in[30:29] == 2'b00 |=> !fast_carry_out)
    else $error("last cell did not kill the carry");

  a_carry_make:
    assert property (cell_in[30:29] == 2'b11 |=> fast_carry_out)
    else $error("last cell did not generate a carry");

  a_tick_one_cycle:
    assert property (tick |=> !tick)
    else $error("block clock tick lasted more than one cycle");

  // a level may only move once stages two and three agreed
  a_gb_filter:
    assert property (1'b1 |=> ((gb_lvl_ff ^ $past(gb_lvl_ff)) & ($past(gb_s2_ff) ^ $past(gb_s3_ff))) == 8'h00)
    else $error("global buffer level moved while stages disagreed");

  a_ce_odd_buf:
    assert property (!ctrl_ff.ce_rt |-> ce_lvl == gb_lvl_ff[{ctrl_ff.ce_idx, 1'b1}])
    else $error("clock enable taken from an even buffer");

  a_gsr_clears_out:
    assert property (gsr && outsel_ff[0] |=> cell_out_ff[0] == plb_pkg::WAKE_STATE[0])
    else $error("registered output not at wake-up state under global reset");

  c_sync_reset:    cover property (ctrl_ff.sr_used && ctrl_ff.sr_sync && sr_lvl && capture);
  c_async_reset:   cover property (ctrl_ff.sr_used && !ctrl_ff.sr_sync && sr_lvl);
  c_carry_out:     cover property (fast_carry_out);
  c_registered:    cover property (outsel_ff != 8'h00 && capture);
  c_enabled_tick:  cover property (ctrl_ff.ce_used && capture);

endmodule

`default_nettype wire

// file: src/plb_pkg.sv
package plb_pkg;

  localparam int unsigned CELLS    = 8;
  localparam int unsigned LUT_BITS = 16;
  localparam int unsigned LUT_IN   = 4;
  localparam int unsigned GBUFS    = 8;

  // apb map, byte addresses
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_OUTSEL = 8'h04;
  localparam logic [7:0] OFF_SRVAL  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_LUT    = 8'h20;
  localparam logic [7:0] LUT_MASK   = 8'he0;

  localparam logic [15:0] RST_LUT    = 16'h0000;
  localparam logic [7:0]  RST_OUTSEL = 8'h00;
  localparam logic [7:0]  RST_SRVAL  = 8'h00;
  localparam logic [7:0]  WAKE_STATE = 8'h00;

  // block control word, low half of the control register
  typedef struct packed {
    logic [1:0] ce_idx;     // odd buffer 2*ce_idx+1
    logic [1:0] sr_idx;     // even buffer 2*sr_idx
    logic       rsvd_hi;
    logic [2:0] clk_idx;
    logic       rsvd_lo;
    logic       clk_rt;
    logic       ce_rt;
    logic       sr_rt;
    logic       ce_used;
    logic       sr_sync;
    logic       sr_used;
    logic       cfg_hold;
  } plb_ctrl_s;

  localparam plb_ctrl_s RST_CTRL = '0;

  typedef struct packed {
    logic [13:0] rsvd;
    logic        cfg_hold;
    logic        carry_out;
    logic [7:0]  cell_out;
    logic [7:0]  ff_q;
  } plb_status_s;

endpackage

// file: tb/plb_fabric.sv
`timescale 1ns/1ns
`default_nettype none
// far side: routing fabric and global buffers, all levels in the clk domain
module plb_fabric (
  input  wire logic        clk,
  output logic             rt_clk,
  output logic             rt_ce,
  output logic             rt_sr,
  output logic [31:0]      cell_in,
  output logic             fast_carry_in,
  output logic [7:0]       global_buffer
);
  initial begin
    {rt_clk, rt_ce, rt_sr, cell_in, fast_carry_in, global_buffer} = '0;
  end

  task automatic set(input logic ce, input logic sr, input logic [31:0] d, input logic c);
    rt_ce <= ce;
    rt_sr <= sr;
    cell_in <= d;
    fast_carry_in <= c;
    @(posedge clk);
  endtask

  // routing clock rests low between pulses, so a source switch sees no edge
  task automatic tick;
    rt_clk <= 1'b1;
    repeat (2) @(posedge clk);
    rt_clk <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // long hold: buffers pass three sync flops before the block sees them
  task automatic gb(input int i, input logic v);
    global_buffer[i] <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: tb/plb_block_test.sv
`timescale 1ns/1ns
`default_nettype none
module plb_block_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  global_buffer;
  logic [7:0]  cell_out;
  logic [31:0] cell_in;
  logic        rt_clk;
  logic        rt_ce;
  logic        rt_sr;
  logic        fast_carry_in;
  logic        fast_carry_out;
  int          errors = 0;
  int          compares = 0;
  int          cyc = 0;
  logic [32:0] expq [$];
  logic [32:0] exp_v;
  logic [31:0] rnd = 32'h7a3f368d;
  logic [15:0] lut_m [8] = '{default: 16'h0};
  logic [7:0]  ff_m = 8'h00;
  logic [7:0]  out_m = 8'h00;
  logic [7:0]  srv_m = 8'h00;
  logic        hold_m = 1'b0;

  always #2 clk = ~clk;

  plb_fabric fab (.clk, .rt_clk, .rt_ce, .rt_sr, .cell_in, .fast_carry_in, .global_buffer);
  plb_block DUT (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .global_buffer, .rt_clk, .rt_ce, .rt_sr, .cell_in, .fast_carry_in, .cell_out, .fast_carry_out);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  function automatic logic [7:0] lv();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) v[i] = lut_m[i][cell_in[4*i+:4]];
    return v;
  endfunction

  // carry uses lookup inputs 1 and 2 of every cell, rippling from cell 0
  function automatic logic [32:0] st();
    logic c;
    c = fast_carry_in;
    for (int i = 0; i < 8; i++) c = (cell_in[4*i+1] & cell_in[4*i+2]) | (c & (cell_in[4*i+1] ^ cell_in[4*i+2]));
    return {15'h0, hold_m, c, (out_m & ff_m) | (~out_m & lv()), ff_m};
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      report_and_stop();
    end
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      exp_v = expq.pop_front();
      check({pslverr, prdata}, exp_v);
      if (paddr == plb_pkg::OFF_STATUS) check({24'h0, fast_carry_out, cell_out}, {24'h0, exp_v[16:8]});
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(plb_pkg::OFF_CTRL, 33'h0);
    rd(plb_pkg::OFF_SRVAL, 33'h0);
    rd(plb_pkg::OFF_STATUS, st());
    rd(8'h10, {1'b1, 32'h0});
    rd(8'h22, {1'b1, 32'h0});
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      lut_m[i] = rnd[15:0];
      apb(1'b1, plb_pkg::OFF_LUT + 8'(4*i), rnd);
      rd(plb_pkg::OFF_LUT + 8'(4*i), {17'h0, rnd[15:0]});
    end
    $display("reset and map test done");
    repeat (6) begin
      rnd = lfsr(rnd);
      fab.set(1'b0, 1'b0, rnd, rnd[31] ^ rnd[0]);
      rd(plb_pkg::OFF_STATUS, st());
    end
    fab.set(1'b0, 1'b0, 32'h22222222, 1'b1);
    rd(plb_pkg::OFF_STATUS, st());
    $display("lookup and carry test done");
    apb(1'b1, plb_pkg::OFF_OUTSEL, 32'hff);
    out_m = 8'hff;
    apb(1'b1, plb_pkg::OFF_CTRL, 32'h68);
    fab.tick();
    rd(plb_pkg::OFF_STATUS, st());
    rnd = lfsr(rnd);
    fab.set(1'b1, 1'b0, rnd, rnd[5]);
    fab.tick();
    ff_m = lv();
    rd(plb_pkg::OFF_STATUS, st());
    srv_m = rnd[23:16];
    apb(1'b1, plb_pkg::OFF_SRVAL, {24'h0, srv_m});
    apb(1'b1, plb_pkg::OFF_CTRL, 32'h7e);
    fab.set(1'b0, 1'b1, cell_in, fast_carry_in);
    fab.tick();
    rd(plb_pkg::OFF_STATUS, st());
    fab.set(1'b1, 1'b1, cell_in, fast_carry_in);
    fab.tick();
    ff_m = srv_m;
    rd(plb_pkg::OFF_STATUS, st());
    fab.set(1'b1, 1'b0, cell_in, fast_carry_in);
    fab.tick();
    ff_m = lv();
    apb(1'b1, plb_pkg::OFF_CTRL, 32'h7a);
    fab.set(1'b0, 1'b1, cell_in, fast_carry_in);
    ff_m = srv_m;
    rd(plb_pkg::OFF_STATUS, st());
    apb(1'b1, plb_pkg::OFF_CTRL, 32'h68);
    fab.set(1'b1, 1'b1, cell_in, fast_carry_in);
    fab.tick();
    ff_m = lv();
    rd(plb_pkg::OFF_STATUS, st());
    $display("enable and set reset test done");
    apb(1'b1, plb_pkg::OFF_CTRL, 32'h69);
    hold_m = 1'b1;
    ff_m = 8'h00;
    rd(plb_pkg::OFF_STATUS, st());
    apb(1'b1, plb_pkg::OFF_CTRL, 32'h650a);
    hold_m = 1'b0;
    fab.set(1'b0, 1'b0, cell_in, fast_carry_in);
    fab.gb(5, 1'b1);
    fab.gb(5, 1'b0);
    rd(plb_pkg::OFF_STATUS, st());
    fab.gb(3, 1'b1);
    fab.gb(5, 1'b1);
    fab.gb(5, 1'b0);
    ff_m = lv();
    rd(plb_pkg::OFF_STATUS, st());
    fab.gb(4, 1'b1);
    ff_m = srv_m;
    rd(plb_pkg::OFF_STATUS, st());
    $display("global buffer test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
